//--- common/ebp_bus_if.sv
`timescale 1ns/10ps
`include "ebp_consts.svh"
interface ebp_bus_if;
  // device end drives; o/oe/i triples per pin group
  logic [23:0] addr_o;
  logic addr_oe;
  logic [23:0] addr_i;
  logic [47:0] data_o;
  logic data_oe;
  logic [47:0] data_i;
  logic [3:0] bank_select_n_o;
  logic bank_select_oe;
  logic [3:0] bank_select_n_i;
  logic rd_n_o;
  logic rd_oe;
  logic rd_n_i;
  logic ack_o;
  logic ack_oe;
  logic ack_i;
  logic suspend_bus_tristate_n;
  logic bus_master;
  // far end: memory, peripheral or another master
  logic [23:0] p_addr_o;
  logic p_addr_oe;
  logic [47:0] p_data_o;
  logic p_data_oe;
  logic p_rd_n_o;
  logic p_rd_oe;
  logic p_ack_o;
  logic p_ack_oe;
  modport dev (
    output addr_o, addr_oe, data_o, data_oe, bank_select_n_o, bank_select_oe, rd_n_o, rd_oe, ack_o, ack_oe,
    input addr_i, data_i, bank_select_n_i, rd_n_i, ack_i, suspend_bus_tristate_n, bus_master
  );
  modport far (
    output p_addr_o, p_addr_oe, p_data_o, p_data_oe, p_rd_n_o, p_rd_oe, p_ack_o, p_ack_oe,
    input addr_i, data_i, bank_select_n_i, rd_n_i, ack_i
  );
endinterface

//--- common/ebp_consts.svh
`ifndef EBP_CONSTS_SVH
`define EBP_CONSTS_SVH
`define EBP_ADDR_W 24
`define EBP_DATA_W 48
`define EBP_IADDR_W 28
`define EBP_BANK_LSB 26
`define EBP_ZERO_LSB 24
`define EBP_NBANKS 4
`define EBP_BANK_WORDS_ASYNC 32'h0100_0000
`define EBP_BANK_WORDS_SDRAM 32'h0400_0000
`define EBP_IPACK_NOPACK 2'h1
`define EBP_SEL_IDLE 4'hf
`define EBP_IOP_WAIT 2'h1
`define EBP_ACK_LAT 3'h4
`define EBP_DEV_PIN_IDLE 80'hfc
`define EBP_FAR_PIN_IDLE 29'h1e00_0001
`endif

//--- common/ebp_pkg.sv
package ebp_pkg;
  typedef enum logic [3:0] {
    EBP_IDLE = 4'h1,
    EBP_ADDR = 4'h2,
    EBP_WAIT = 4'h4,
    EBP_DONE = 4'h8
  } ebp_state_t;
  typedef enum logic [1:0] {
    EBP_S_IDLE = 2'h1,
    EBP_S_WAIT = 2'h2
  } ebp_sstate_t;
endpackage

//--- hdl/ebp_dev_end.sv
`timescale 1ns/10ps
`include "ebp_consts.svh"
// Notes on behaviour
// - master drives address of each access
// - address lines are inputs during slave access
// - other masters reach only io registers
// - link data pins extend low data
// - packing field 0x1 with link ports off runs unpacked 48-bit
// - one low bank select, address decoded
// - banks fixed 16M or 64M words
// - async: selects change with address
// - sync: selects drop after ack seen
// - bits 25:24 zero for async banks, 27:26 pick bank
// - slave watches master's bank selects
// - master asserts read strobe on reads
// - outsider asserts strobe to read registers
// - only bus owner drives read strobe
// - inputs sampled on input clock
// - tristate when suspended or slave
// - halt during emulation, resume unaffected
// - far end holds ack low to wait
// - drive ack low on sync register access
module ebp_dev_end
  import ebp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  ebp_bus_if.dev bus,
  input wire logic req_i,
  input wire logic req_rd_i,
  input wire logic [27:0] req_addr_i,
  input wire logic [47:0] req_wdata_i,
  input wire logic sync_mode_i,
  input wire logic sdram_bank_i,
  input wire logic link_ports_off_i,
  input wire logic [1:0] instruction_packing_field_i,
  input wire logic emu_halt_i,
  input wire logic [47:0] iop_rdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [47:0] rdata_o,
  output logic bad_addr_o,
  output logic unpacked_o,
  output logic iop_rd_o,
  output logic [23:0] iop_addr_o,
  output logic [3:0] watched_sel_n_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ebp_state_t st;
    ebp_sstate_t sst;
    logic [23:0] addr;
    logic [47:0] wdata;
    logic rd;
    logic [3:0] sel_n;
    logic rd_n;
    logic drive;
    logic done;
    logic [47:0] rdata;
    logic bad;
    logic unpacked;
    logic iop_rd;
    logic [23:0] iop_addr;
    logic [3:0] watched;
    logic [1:0] wcnt;
    logic ack_drv;
    logic [2:0] lat;
    logic ready;
    logic doe;
    logic [47:0] odata;
  } ebp_dev_t;
  ebp_dev_t s_q, s_d;

  // ****************************************
  // synchronised pins
  // ****************************************
  logic [23:0] addr_s;
  logic [47:0] data_s;
  logic [3:0] sel_s;
  logic rd_s, ack_s, suspend_bus_tristate_n_s, master_s;
  ebp_sync #(.W(24 + 48 + 4 + 4), .INIT(`EBP_DEV_PIN_IDLE)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({bus.addr_i, bus.data_i, bus.bank_select_n_i, bus.rd_n_i, bus.ack_i,
          bus.suspend_bus_tristate_n, bus.bus_master}),
    .q_o({addr_s, data_s, sel_s, rd_s, ack_s, suspend_bus_tristate_n_s, master_s})
  );

  // one-hot low select from internal address
  function automatic logic [3:0] bank_dec(input logic [27:0] a);
    logic [3:0] r;
    r = `EBP_SEL_IDLE;
    r[a[27:26]] = 1'b0;
    return r;
  endfunction

  // bits 25:24 must be clear to reach an async bank
  function automatic logic addr_ok(input logic [27:0] a, input logic sd);
    // sdram banks span 64M words so bits 25:24 belong to the bank then
    return sd ? 1'b1 : (a[25:24] == 2'h0);
  endfunction

  logic may_run;
  // halted for emulation or suspended: no new access starts
  assign may_run = !emu_halt_i && suspend_bus_tristate_n_s && master_s;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.iop_rd = 1'b0;
    s_d.watched = sel_s;
    s_d.unpacked = link_ports_off_i && (instruction_packing_field_i == `EBP_IPACK_NOPACK);
    s_d.drive = master_s && suspend_bus_tristate_n_s;
    case (s_q.st)
      EBP_IDLE: begin
        s_d.sel_n = `EBP_SEL_IDLE;
        s_d.rd_n = 1'b1;
        if (req_i && may_run) begin
          if (addr_ok(req_addr_i, sdram_bank_i)) begin
            s_d.addr = req_addr_i[23:0];
            s_d.wdata = req_wdata_i;
            s_d.rd = req_rd_i;
            s_d.sel_n = bank_dec(req_addr_i);
            s_d.rd_n = !req_rd_i;
            s_d.st = EBP_ADDR;
            s_d.lat = `EBP_ACK_LAT;
          end else begin
            s_d.bad = 1'b1;
            s_d.done = 1'b1;
          end
        end
      end
      EBP_ADDR: begin
        if (!emu_halt_i) begin
          s_d.st = EBP_WAIT;
        end
      end
      EBP_WAIT: begin
        // ack low stretches the access; asynchronous mode also waits on it
        if (s_q.lat != 3'h0) begin
          // the pulled-up idle ack means nothing until the far end's answer crossed both syncs
          s_d.lat = s_q.lat - 3'h1;
        end else if (ack_s && !emu_halt_i) begin
          s_d.rdata = data_s;
          if (sync_mode_i) begin
            s_d.sel_n = `EBP_SEL_IDLE;
            s_d.rd_n = 1'b1;
          end
          s_d.st = EBP_DONE;
        end
      end
      EBP_DONE: begin
        s_d.sel_n = `EBP_SEL_IDLE;
        s_d.rd_n = 1'b1;
        s_d.done = 1'b1;
        s_d.bad = 1'b0;
        s_d.st = EBP_IDLE;
      end
      default: begin
        s_d.st = EBP_IDLE;
      end
    endcase
    // slave side: outside master reads io registers
    case (s_q.sst)
      EBP_S_IDLE: begin
        s_d.ack_drv = 1'b0;
        if (!master_s && !rd_s) begin
          s_d.iop_addr = addr_s;
          s_d.iop_rd = 1'b1;
          s_d.wcnt = `EBP_IOP_WAIT;
          s_d.ack_drv = sync_mode_i;
          s_d.sst = EBP_S_WAIT;
        end
      end
      EBP_S_WAIT: begin
        if (s_q.wcnt != 2'h0) begin
          s_d.wcnt = s_q.wcnt - 2'h1;
        end else begin
          s_d.ack_drv = 1'b0;
          if (rd_s) begin
            s_d.sst = EBP_S_IDLE;
          end
        end
      end
      default: begin
        s_d.sst = EBP_S_IDLE;
      end
    endcase
    // pin-facing outputs are registered too, so none leaves through decode logic
    s_d.ready = (s_d.st == EBP_IDLE);
    s_d.doe = s_d.drive && (s_d.st != EBP_IDLE) && !s_d.rd;
    s_d.odata = s_d.rd ? iop_rdata_i : s_d.wdata;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{st: EBP_IDLE, sst: EBP_S_IDLE, sel_n: `EBP_SEL_IDLE, rd_n: 1'b1, watched: `EBP_SEL_IDLE,
               ready: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // pins and user outputs
  // ****************************************
  assign bus.addr_o = s_q.addr;
  assign bus.addr_oe = s_q.drive;
  assign bus.data_o = s_q.odata;
  assign bus.data_oe = s_q.doe;
  assign bus.bank_select_n_o = s_q.sel_n;
  assign bus.bank_select_oe = s_q.drive;
  assign bus.rd_n_o = s_q.rd_n;
  assign bus.rd_oe = s_q.drive;
  assign bus.ack_o = 1'b0;
  assign bus.ack_oe = s_q.ack_drv;
  assign req_ready_o = s_q.ready;
  assign done_o = s_q.done;
  assign rdata_o = s_q.rdata;
  assign bad_addr_o = s_q.bad;
  assign unpacked_o = s_q.unpacked;
  assign iop_rd_o = s_q.iop_rd;
  assign iop_addr_o = s_q.iop_addr;
  assign watched_sel_n_o = s_q.watched;
endmodule

//--- hdl/ebp_far_end.sv
`timescale 1ns/10ps
`include "ebp_consts.svh"
module ebp_far_end
  import ebp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  ebp_bus_if.far bus,
  input wire logic [1:0] wait_states_i,
  input wire logic [47:0] mem_rdata_i,
  output logic [3:0] hit_bank_o,
  output logic [23:0] hit_addr_o,
  output logic hit_o
);
  typedef struct packed {
    logic [1:0] cnt;
    logic ack;
    logic busy;
    logic hit;
    logic [3:0] bank;
    logic [23:0] addr;
  } ebp_far_t;
  ebp_far_t s_q, s_d;
  logic [3:0] sel_s;
  logic [23:0] addr_s;
  logic rd_s;

  ebp_sync #(.W(29), .INIT(`EBP_FAR_PIN_IDLE)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({bus.bank_select_n_i, bus.addr_i, bus.rd_n_i}),
    .q_o({sel_s, addr_s, rd_s})
  );

  // memory side: answer a selected bank, holding ack low for wait states
  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    if (!s_q.busy) begin
      s_d.ack = 1'b1;
      if (sel_s != `EBP_SEL_IDLE) begin
        s_d.busy = 1'b1;
        s_d.cnt = wait_states_i;
        s_d.ack = (wait_states_i == 2'h0);
        s_d.bank = ~sel_s;
        s_d.addr = addr_s;
        s_d.hit = 1'b1;
      end
    end else begin
      if (s_q.cnt != 2'h0) begin
        s_d.cnt = s_q.cnt - 2'h1;
      end
      s_d.ack = (s_q.cnt <= 2'h1);
      if (sel_s == `EBP_SEL_IDLE) begin
        s_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{ack: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // memory never drives the strobe; only bus owners do
  assign bus.p_rd_n_o = 1'b1;
  assign bus.p_rd_oe = 1'b0;
  assign bus.p_addr_o = '0;
  assign bus.p_addr_oe = 1'b0;
  assign bus.p_data_o = mem_rdata_i;
  assign bus.p_data_oe = s_q.busy && !rd_s;
  assign bus.p_ack_o = s_q.ack;
  assign bus.p_ack_oe = s_q.busy;
  assign hit_bank_o = s_q.bank;
  assign hit_addr_o = s_q.addr;
  assign hit_o = s_q.hit;
endmodule

//--- hdl/ebp_sync.sv
`timescale 1ns/10ps
module ebp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // two-stage pin synchroniser; first stage feeds only the second
  // reset to the pins' idle levels so no false strobe or select follows reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= INIT;
      q_o <= INIT;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

//--- tb/ebp_checker.sv
`timescale 1ns/10ps
// ****************
// bus pin checker
// ****************
module ebp_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic addr_oe,
  input wire logic [3:0] bank_select_n_o,
  input wire logic bank_select_oe,
  input wire logic rd_n_o,
  input wire logic rd_oe,
  input wire logic ack_o,
  input wire logic ack_oe,
  input wire logic suspend_bus_tristate_n,
  input wire logic bus_master
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // owner and suspend inputs pass two sync flops and the drive register, hence the run of four
  a_one_select: assert property (bank_select_n_o != 4'hf |-> $onehot(~bank_select_n_o))
    else $error("two selects low");
  a_slave_float: assert property (!bus_master [*4] |-> !addr_oe && !rd_oe && !bank_select_oe)
    else $error("slave drives bus");
  a_suspend_float: assert property (!suspend_bus_tristate_n [*4] |-> !addr_oe && !bank_select_oe)
    else $error("suspended bus driven");
  a_sel_release: assert property (bank_select_oe && bank_select_n_o != 4'hf |->
    ##[1:24] (bank_select_n_o == 4'hf || !bank_select_oe))
    else $error("select never released");
  a_rd_in_access: assert property (rd_oe && !rd_n_o |-> bank_select_n_o != 4'hf)
    else $error("read strobe outside access");
  a_sel_with_addr: assert property (bank_select_n_o != 4'hf && $past(bank_select_n_o) == 4'hf |-> addr_oe)
    else $error("select without address");
  // a sync-mode register read by another master is stretched by exactly two low ack cycles
  a_ack_low: assert property ($rose(ack_oe) |-> !ack_o ##1 (ack_oe && !ack_o) ##1 !ack_oe)
    else $error("ack wait not two cycles low");
  a_ack_slave: assert property (ack_oe |-> !rd_oe && !bank_select_oe)
    else $error("ack driven as master");
  c_read: cover property (bank_select_oe && !rd_n_o);
  c_slave_ack: cover property (ack_oe);
  c_suspend: cover property (!suspend_bus_tristate_n [*4]);
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
// ****************
// both ends bench
// ****************
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_i = 1'b0, req_rd_i = 1'b0, sync_mode_i = 1'b0, sdram_bank_i = 1'b0;
  logic link_ports_off_i = 1'b0, emu_halt_i = 1'b0, master = 1'b1, suspend_n = 1'b1, tb_rd = 1'b1;
  logic [27:0] req_addr_i = 28'h0;
  logic [47:0] req_wdata_i = 48'h0, iop_rdata_i = 48'h0, mem_rdata_i = 48'h0;
  logic [1:0] instruction_packing_field_i = 2'h0, wait_states_i = 2'h0;
  logic [23:0] tb_addr = 24'h0;
  logic [3:0] tb_sel = 4'hf;
  logic req_ready_o, done_o, bad_addr_o, unpacked_o, iop_rd_o, hit_o, got, ackl;
  logic [47:0] rdata_o;
  logic [23:0] iop_addr_o, hit_addr_o, ga;
  logic [3:0] watched_sel_n_o, hit_bank_o;
  logic [31:0] r;
  logic [27:0] a;
  int failures = 0, num_checks = 0, seed = 98;
  // free-running 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;
  ebp_bus_if u_bus ();
  // wire levels; ack floats high on its pull-up
  assign u_bus.addr_i = u_bus.addr_oe ? u_bus.addr_o : u_bus.p_addr_oe ? u_bus.p_addr_o : tb_addr;
  assign u_bus.data_i = u_bus.data_oe ? u_bus.data_o : u_bus.p_data_oe ? u_bus.p_data_o : ~u_bus.data_o;
  assign u_bus.bank_select_n_i = u_bus.bank_select_oe ? u_bus.bank_select_n_o : tb_sel;
  assign u_bus.rd_n_i = u_bus.rd_oe ? u_bus.rd_n_o : u_bus.p_rd_oe ? u_bus.p_rd_n_o : tb_rd;
  assign u_bus.ack_i = u_bus.ack_oe ? u_bus.ack_o : u_bus.p_ack_oe ? u_bus.p_ack_o : 1'b1;
  assign u_bus.suspend_bus_tristate_n = suspend_n;
  assign u_bus.bus_master = master;
  ebp_dev_end u_ebp_dev_end (.sys_clk_i, .rst_b_i, .bus(u_bus), .req_i, .req_rd_i, .req_addr_i,
    .req_wdata_i, .sync_mode_i, .sdram_bank_i, .link_ports_off_i, .instruction_packing_field_i,
    .emu_halt_i, .iop_rdata_i, .req_ready_o, .done_o, .rdata_o, .bad_addr_o, .unpacked_o,
    .iop_rd_o, .iop_addr_o, .watched_sel_n_o);
  ebp_far_end u_ebp_far_end (.sys_clk_i, .rst_b_i, .bus(u_bus), .wait_states_i, .mem_rdata_i,
    .hit_bank_o, .hit_addr_o, .hit_o);
  ebp_checker u_ebp_checker (.sys_clk_i, .rst_b_i, .addr_oe(u_bus.addr_oe),
    .bank_select_n_o(u_bus.bank_select_n_o), .bank_select_oe(u_bus.bank_select_oe),
    .rd_n_o(u_bus.rd_n_o), .rd_oe(u_bus.rd_oe), .ack_o(u_bus.ack_o), .ack_oe(u_bus.ack_oe),
    .suspend_bus_tristate_n(suspend_n), .bus_master(master));
  function automatic logic [3:0] sel_exp(input logic [27:0] x);
    return ~(4'h1 << x[27:26]);
  endfunction
  function automatic logic [3:0] hot(input logic [27:0] x);
    return 4'h1 << x[27:26];
  endfunction
  function automatic logic unp_exp(input logic [2:0] c);
    return c[2] && c[1:0] == 2'h1;
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one access; request dropped once its bus cycle shows, so it is not retaken
  task automatic access(input logic rd, input logic [27:0] x, input logic bad);
    logic [31:0] r1 = $random(seed);
    logic [31:0] r2 = $random(seed);
    logic [3:0] sel = 4'hf;
    logic [3:0] hb = 4'h0;
    logic [23:0] ha = 24'h0;
    logic rds = 1'b1;
    logic [47:0] wd = 48'h0;
    int n = 0;
    @(posedge sys_clk_i);
    #1;
    req_i = 1'b1;
    req_rd_i = rd;
    req_addr_i = x;
    req_wdata_i = {r1[15:0], r2};
    mem_rdata_i = {r2[15:0], r1};
    while (done_o !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (u_bus.bank_select_n_i != 4'hf) sel = u_bus.bank_select_n_i;
      if (u_bus.rd_n_i === 1'b0) rds = 1'b0;
      if (!rd && u_bus.bank_select_n_i != 4'hf) wd = u_bus.data_i;
      if (hit_o === 1'b1) hb = hit_bank_o;
      if (hit_o === 1'b1) ha = hit_addr_o;
      if (sel != 4'hf || done_o === 1'b1) req_i = 1'b0;
      if (n > 60) begin
        chk("access_timeout", 48'h0, 48'h1);
        conclude();
      end
    end
    chk("bad_addr", bad, bad_addr_o);
    chk("req_ready", 1'b1, req_ready_o);
    chk("sel_wire", bad ? 4'hf : sel_exp(x), sel);
    if (!bad) begin
      chk("hit_bank", hot(x), hb);
      chk("hit_addr", x[23:0], ha);
      chk("rd_strobe", !rd, rds);
      if (rd) chk("rdata", {r2[15:0], r1}, rdata_o);
      else chk("wdata", {r1[15:0], r2}, wd);
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    chk("reset_idle", 5'h1f, {u_bus.bank_select_n_o, u_bus.rd_n_o});
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      sync_mode_i = r[0];
      wait_states_i = r[2:1];
      a = (i == 0) ? 28'h0 : (i == 1) ? 28'hcff_ffff : {r[5:4], 2'h0, r[31:8]};
      access(r[3], a, 1'b0);
    end
    access(1'b1, 28'h900_0040, 1'b1);
    sdram_bank_i = 1'b1;
    access(1'b0, 28'h900_0040, 1'b0);
    sdram_bank_i = 1'b0;
    // bus suspended, then core halted, with a request waiting
    for (int k = 0; k < 2; k++) begin
      suspend_n = k[0];
      emu_halt_i = k[0];
      // the suspend pin crosses two sync flops before a request may meet it
      repeat (3) @(posedge sys_clk_i);
      #1;
      fork
        access(1'b1, 28'h400_0123, 1'b0);
        begin
          repeat (8) begin
            @(posedge sys_clk_i);
            #1;
            chk("held_bus", 5'h0f, {done_o, u_bus.bank_select_n_i});
          end
          suspend_n = 1'b1;
          emu_halt_i = 1'b0;
        end
      join
    end
    for (int k = 0; k < 8; k++) begin
      {link_ports_off_i, instruction_packing_field_i} = k[2:0];
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("unpacked", unp_exp(k[2:0]), unpacked_o);
    end
    // another master reads our io registers in sync mode
    sync_mode_i = 1'b1;
    master = 1'b0;
    got = 1'b0;
    ackl = 1'b0;
    ga = 24'h0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    r = $random(seed);
    tb_addr = r[23:0];
    iop_rdata_i = {r[15:0], r};
    tb_sel = 4'hb;
    tb_rd = 1'b0;
    repeat (12) begin
      @(posedge sys_clk_i);
      #1;
      if (iop_rd_o === 1'b1) got = 1'b1;
      if (iop_rd_o === 1'b1) ga = iop_addr_o;
      // only the device's own low ack counts; the memory end may also be answering
      if (u_bus.ack_oe === 1'b1 && u_bus.ack_i === 1'b0) ackl = 1'b1;
    end
    tb_rd = 1'b1;
    chk("iop_read", 1'b1, got);
    chk("iop_addr", r[23:0], ga);
    chk("ack_wait", 1'b1, ackl);
    chk("watched_sel", 4'hb, watched_sel_n_o);
    conclude();
  end
endmodule
